// >>> rtl/prfam_monitor.sv
// Receive-only 1544 kbit/s framing, line code and alarm monitor
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module prfam_monitor (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [prfam_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic line_clk_i,
  input wire logic line_pos_i,
  input wire logic line_neg_i,
  output logic lof_o,
  output logic all_ones_alarm_o,
  output logic dist_alarm_o,
  output logic code_mismatch_o,
  output logic dl_bit_o,
  output logic dl_strobe_o
);
  import prfam_pkg::*;

  typedef enum {FR_HUNT, FR_SYNC} prfam_frm_state_t;

  // Pin synchronisers; the line clock is sampled and edge detected
  logic [1:0] clk_sync_reg, pos_sync_reg, neg_sync_reg;
  logic clk_prev_reg;
  logic bit_en, pulse;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_sync_reg <= 2'h0;
      pos_sync_reg <= 2'h0;
      neg_sync_reg <= 2'h0;
      clk_prev_reg <= 1'b0;
    end else begin
      clk_sync_reg <= {clk_sync_reg[0], line_clk_i};
      pos_sync_reg <= {pos_sync_reg[0], line_pos_i};
      neg_sync_reg <= {neg_sync_reg[0], line_neg_i};
      clk_prev_reg <= clk_sync_reg[1];
    end
  end

  assign bit_en = clk_sync_reg[1] & ~clk_prev_reg;
  assign pulse = pos_sync_reg[1] | neg_sync_reg[1];

  // Register bus state
  logic [1:0] ctrl_reg;
  logic ack_reg, req, wr_fire, ctrl_b8zs, ctrl_esf;
  logic [3:0] latch_reg, lat_clr;
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_fire = req & wb_we_i & ack_reg;
  assign ctrl_b8zs = ctrl_reg[CTRL_B8ZS];
  assign ctrl_esf = ctrl_reg[CTRL_ESF];

  // Bipolar decoder: eight-symbol window so a B8ZS block can be removed
  logic last_pol_reg, rx_b8zs_reg;
  logic [7:0] mark_sr_reg, bpv_sr_reg, mark_next, bpv_next;
  logic [3:0] zrun_reg;
  logic bpv, subst, dbit, iso_bpv, zrun_hit, mismatch_ev;
  assign bpv = pulse & (pos_sync_reg[1] == last_pol_reg);
  assign mark_next = {mark_sr_reg[6:0], pulse};
  assign bpv_next = {bpv_sr_reg[6:0], bpv};
  assign subst = (mark_next == B8ZS_MARKS) && (bpv_next == B8ZS_BPVS);
  assign dbit = mark_sr_reg[7];
  // Violations that leave the window unpaired are true code violations
  assign iso_bpv = bit_en & bpv_sr_reg[7];
  assign zrun_hit = bit_en & ~pulse & (zrun_reg == ZRUN_LAST);
  assign mismatch_ev = (bit_en & subst & ~ctrl_b8zs) | (zrun_hit & ctrl_b8zs);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_pol_reg <= 1'b0;
      mark_sr_reg <= 8'h0;
      bpv_sr_reg <= 8'h0;
      zrun_reg <= 4'h0;
      rx_b8zs_reg <= 1'b0;
    end else if (bit_en) begin
      if (pulse) begin
        last_pol_reg <= pos_sync_reg[1];
      end
      mark_sr_reg <= (subst & ctrl_b8zs) ? 8'h0 : mark_next;
      bpv_sr_reg <= subst ? 8'h0 : bpv_next;
      if (pulse) begin
        zrun_reg <= 4'h0;
      end else if (zrun_reg != ZRUN_SAT) begin
        zrun_reg <= zrun_reg + 4'h1;
      end
      if (subst) begin
        rx_b8zs_reg <= 1'b1;
      end else if (zrun_hit) begin
        rx_b8zs_reg <= 1'b0;
      end
    end
  end

  // Frame aligner
  prfam_frm_state_t st_reg;
  logic [7:0] bit_cnt_reg;
  logic [4:0] frm_cnt_reg;
  logic [23:0] fhist_reg, fh_next;
  logic [5:0] hunt_cnt_reg, mf_len;
  logic [3:0] err_hist_reg, err_next;
  logic [2:0] err_sum;
  logic lof, fbit_en, hunt_match, found_evt, slip_evt, fchk, fexp;
  logic ferr_evt, lof_evt;

  assign lof = (st_reg == FR_HUNT);
  assign fbit_en = bit_en & (bit_cnt_reg == 8'h0);
  assign fh_next = {fhist_reg[22:0], dbit};
  assign mf_len = ctrl_esf ? ESF_FRAMES : SF_FRAMES;
  assign hunt_match = ctrl_esf ?
    ({fh_next[20], fh_next[16], fh_next[12], fh_next[8], fh_next[4],
      fh_next[0]} == ESF_FPS) : (fh_next[11:0] == SF_PATTERN);
  assign found_evt = fbit_en & lof & (hunt_cnt_reg + 6'h1 >= mf_len) &
    hunt_match;
  // A candidate gets two multiframes; then move it by one bit
  assign slip_evt = fbit_en & lof & ~found_evt &
    (hunt_cnt_reg + 6'h1 == {mf_len[4:0], 1'b0});
  assign fchk = ~ctrl_esf | (frm_cnt_reg[1:0] == 2'h3);
  assign fexp = ctrl_esf ? ESF_FPS[ESF_FPS_TOP - frm_cnt_reg[4:2]] :
    SF_PATTERN[SF_PAT_TOP - frm_cnt_reg[3:0]];
  assign ferr_evt = fbit_en & ~lof & fchk & (dbit != fexp);
  assign err_next = {err_hist_reg[2:0], ferr_evt};
  assign err_sum = {2'h0, err_next[0]} + {2'h0, err_next[1]} +
    {2'h0, err_next[2]} + {2'h0, err_next[3]};
  assign lof_evt = fbit_en & ~lof & fchk & (err_sum >= LOF_ERR_LIMIT);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= FR_HUNT;
      bit_cnt_reg <= 8'h0;
      frm_cnt_reg <= 5'h0;
      fhist_reg <= 24'h0;
      hunt_cnt_reg <= 6'h0;
      err_hist_reg <= 4'h0;
    end else if (bit_en) begin
      if (slip_evt || bit_cnt_reg == FRAME_LAST) begin
        bit_cnt_reg <= 8'h0;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 8'h1;
      end
      if (fbit_en) begin
        case (st_reg)
          FR_HUNT: begin
            fhist_reg <= fh_next;
            hunt_cnt_reg <= slip_evt ? 6'h0 : hunt_cnt_reg + 6'h1;
            if (found_evt) begin
              st_reg <= FR_SYNC;
              frm_cnt_reg <= 5'h0;
              err_hist_reg <= 4'h0;
            end
          end
          FR_SYNC: begin
            // Wrap with >= so a structure change mid-run cannot overrun
            if ({1'b0, frm_cnt_reg} >= mf_len - 6'h1) begin
              frm_cnt_reg <= 5'h0;
            end else begin
              frm_cnt_reg <= frm_cnt_reg + 5'h1;
            end
            if (fchk) begin
              err_hist_reg <= err_next;
            end
            if (lof_evt) begin
              st_reg <= FR_HUNT;
              hunt_cnt_reg <= 6'h0;
            end
          end
          default: begin
            st_reg <= FR_HUNT;
          end
        endcase
      end
    end
  end

  // CRC-6 over each 24-frame multiframe, framing bits taken as ones
  logic [5:0] crc_reg, crc_prev_reg, rx_crc_reg;
  logic [1:0] mf_seen_reg;
  logic mf_start, crc_err_evt;

  function automatic logic [5:0] crc_step(input logic [5:0] c,
                                          input logic d);
    crc_step = {c[4:0], 1'b0} ^ ({6{c[5] ^ d}} & CRC6_POLY);
  endfunction

  assign mf_start = fbit_en & ~lof & ctrl_esf & (frm_cnt_reg == 5'h0);
  assign crc_err_evt = mf_start & mf_seen_reg[1] &
    (rx_crc_reg != crc_prev_reg);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      crc_reg <= 6'h0;
      crc_prev_reg <= 6'h0;
      rx_crc_reg <= 6'h0;
      mf_seen_reg <= 2'h0;
    end else if (lof || !ctrl_esf) begin
      mf_seen_reg <= 2'h0;
    end else if (bit_en) begin
      if (mf_start) begin
        crc_prev_reg <= crc_reg;
        crc_reg <= crc_step(6'h0, 1'b1);
        if (!mf_seen_reg[1]) begin
          mf_seen_reg <= mf_seen_reg + 2'h1;
        end
      end else begin
        crc_reg <= crc_step(crc_reg, fbit_en | dbit);
      end
      if (fbit_en && frm_cnt_reg[1:0] == 2'h1) begin
        rx_crc_reg <= {rx_crc_reg[4:0], dbit};
      end
    end
  end

  // Data link bits sit in the odd frames of the 24-frame structure
  logic dl_en, dl_bit_reg, dl_strobe_reg;
  assign dl_en = fbit_en & ~lof & ctrl_esf & ~frm_cnt_reg[0];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dl_bit_reg <= 1'b0;
      dl_strobe_reg <= 1'b0;
    end else begin
      dl_strobe_reg <= dl_en;
      if (dl_en) begin
        dl_bit_reg <= dbit;
      end
    end
  end

  // All-ones alarm: few zeros in the window; sparse violations pass
  logic [11:0] ones_win_reg;
  logic [3:0] ones_zero_reg;
  logic ones_alm_reg, ones_end;
  assign ones_end = bit_en & (ones_win_reg == ONES_WIN_LAST);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ones_win_reg <= 12'h0;
      ones_zero_reg <= 4'h0;
      ones_alm_reg <= 1'b0;
    end else if (ones_end) begin
      ones_win_reg <= 12'h0;
      ones_zero_reg <= 4'h0;
      ones_alm_reg <= (ones_zero_reg <= ONES_MAX_ZEROS);
    end else if (bit_en) begin
      ones_win_reg <= ones_win_reg + 12'h1;
      if (!dbit && ones_zero_reg != 4'hf) begin
        ones_zero_reg <= ones_zero_reg + 4'h1;
      end
    end
  end

  // Distant alarm: bit 2 low in all but at most eight slots of the window in 12-frame mode, or at least four alarm words on the link in 24-frame mode
  logic [7:0] da_frm_reg;
  logic [3:0] da_ones_reg;
  logic [2:0] da_words_reg;
  logic [15:0] dl_hist_reg, dl_hist_next;
  logic dist_reg, da_bit, da_end;
  assign da_bit = bit_en & ~lof & ~ctrl_esf & (bit_cnt_reg[2:0] == 3'h2);
  assign dl_hist_next = {dl_hist_reg[14:0], dbit};
  assign da_end = fbit_en & ~lof & (da_frm_reg == DA_WIN_LAST);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      da_frm_reg <= 8'h0;
      da_ones_reg <= 4'h0;
      da_words_reg <= 3'h0;
      dl_hist_reg <= 16'h0;
      dist_reg <= 1'b0;
    end else if (lof) begin
      da_frm_reg <= 8'h0;
      da_ones_reg <= 4'h0;
      da_words_reg <= 3'h0;
      dist_reg <= 1'b0;
    end else if (da_end) begin
      da_frm_reg <= 8'h0;
      da_ones_reg <= 4'h0;
      da_words_reg <= 3'h0;
      dist_reg <= ctrl_esf ? (da_words_reg >= DA_ESF_MIN_WORDS) :
        (da_ones_reg <= DA_SF_MAX_ONES);
    end else begin
      if (fbit_en) begin
        da_frm_reg <= da_frm_reg + 8'h1;
      end
      if (da_bit && dbit && da_ones_reg != 4'hf) begin
        da_ones_reg <= da_ones_reg + 4'h1;
      end
      if (dl_en) begin
        dl_hist_reg <= dl_hist_next;
        if (dl_hist_next == DA_ESF_WORD && da_words_reg != 3'h7) begin
          da_words_reg <= da_words_reg + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_reg <= 4'h0;
    end else begin
      latch_reg <= {mismatch_ev, dist_reg, ones_alm_reg, lof} |
        (latch_reg & ~lat_clr);
    end
  end

  assign lof_o = latch_reg[ST_LOF];
  assign all_ones_alarm_o = latch_reg[ST_ONES];
  assign dist_alarm_o = latch_reg[ST_DIST];
  assign code_mismatch_o = latch_reg[ST_MISMATCH];
  assign dl_bit_o = dl_bit_reg;
  assign dl_strobe_o = dl_strobe_reg;

  // Event counters: loss count, framing errors, CRC errors, violations
  logic [CNT_W-1:0] cnt_val [NUM_CNT];
  logic [NUM_CNT-1:0] cnt_ovf, cnt_inc, cnt_clr;
  logic cnt_hit;
  assign cnt_hit = wr_fire & (wb_adr_i[7:4] == CNT_PAGE) &
    (wb_adr_i[1:0] == 2'h0);
  assign cnt_inc = {iso_bpv & ~lof, crc_err_evt, ferr_evt, lof_evt};

  for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
    assign cnt_clr[i] = cnt_hit & (wb_adr_i[3:2] == 2'(i));
    prfam_event_counter u_cnt (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .inc(cnt_inc[i]),
      .clr(cnt_clr[i]),
      .count_reg(cnt_val[i]),
      .ovf_reg(cnt_ovf[i])
    );
  end

  // Wishbone slave: one wait state, write lands on the acked edge
  logic [31:0] rd_data, dat_reg;
  assign lat_clr = (wr_fire && wb_adr_i == ADDR_LATCH && wb_sel_i[0]) ?
    wb_dat_i[3:0] : 4'h0;

  always_comb begin
    rd_data = 32'h0;
    case (wb_adr_i)
      ADDR_CTRL: rd_data[1:0] = ctrl_reg;
      ADDR_STATUS: rd_data[4:0] = {rx_b8zs_reg, 1'b0, dist_reg,
        ones_alm_reg, lof};
      ADDR_LATCH: rd_data[3:0] = latch_reg;
      default: begin
        if (wb_adr_i[7:4] == CNT_PAGE && wb_adr_i[1:0] == 2'h0) begin
          rd_data = {cnt_ovf[wb_adr_i[3:2]], 14'h0, cnt_val[wb_adr_i[3:2]]};
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
      ctrl_reg <= CTRL_RESET;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (req && !ack_reg) begin
        dat_reg <= rd_data;
      end
      if (wr_fire && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
        ctrl_reg <= wb_dat_i[1:0];
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence bus_req_s;
    req && !ack_reg;
  endsequence
  sequence ack_pulse_s;
    ack_reg ##1 !ack_reg;
  endsequence
  sequence lof_set_s;
    lof ##1 lof_o;
  endsequence

  bus_ack_a: assert property (bus_req_s |=> ack_pulse_s)
    else $error("bus ack not a single pulse after request");
  b8zs_strip_a: assert property (
    bit_en && subst && ctrl_b8zs |=> mark_sr_reg == 8'h0)
    else $error("substitution block not removed");
  code_mismatch_a: assert property (
    bit_en && subst && !ctrl_b8zs |=> code_mismatch_o)
    else $error("B8ZS under AMI not flagged");
  lof_declare_a: assert property (lof_evt |=> lof_set_s)
    else $error("loss of alignment not indicated");
  realign_a: assert property (found_evt |=> !lof)
    else $error("alignment not regained");
  ones_detect_a: assert property (
    ones_end && ones_zero_reg <= ONES_MAX_ZEROS |=> ones_alm_reg ##1
    all_ones_alarm_o)
    else $error("all-ones alarm missed");
  dist_detect_a: assert property (
    da_end && !ctrl_esf && da_ones_reg <= DA_SF_MAX_ONES |=> dist_reg)
    else $error("distant alarm missed");
  lof_count_a: assert property (
    lof_evt && !cnt_clr[0] && cnt_val[0] != CNT_MAX
    |=> cnt_val[0] == $past(cnt_val[0]) + 1'b1)
    else $error("loss count not advanced");
  crc_check_a: assert property (
    crc_err_evt |-> ctrl_esf && !lof && mf_seen_reg == 2'h2)
    else $error("CRC error outside checked multiframe");
  latch_hold_a: assert property (
    all_ones_alarm_o && !lat_clr[ST_ONES] |=> all_ones_alarm_o)
    else $error("latched alarm dropped without clear");
  cnt_gate_a: assert property (
    lof |-> cnt_inc[3:1] == 3'h0)
    else $error("error counter ran during loss of alignment");
endmodule
`default_nettype wire

// >>> rtl/prfam_pkg.sv
// Constants shared by the 1544 kbit/s frame and alarm monitor
package prfam_pkg;
  // Register map (byte addresses, one word each)
  localparam int ADR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LATCH = 8'h08;
  localparam logic [7:0] ADDR_LOF_CNT = 8'h10;
  localparam logic [7:0] ADDR_FERR_CNT = 8'h14;
  localparam logic [7:0] ADDR_CRC_CNT = 8'h18;
  localparam logic [7:0] ADDR_CV_CNT = 8'h1c;
  localparam logic [3:0] CNT_PAGE = ADDR_LOF_CNT[7:4];
  localparam int NUM_CNT = 4;

  // Control fields
  localparam int CTRL_B8ZS = 0;
  localparam int CTRL_ESF = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Status and latch field positions
  localparam int ST_LOF = 0;
  localparam int ST_ONES = 1;
  localparam int ST_DIST = 2;
  localparam int ST_MISMATCH = 3;

  // Event counters
  localparam int CNT_W = 17;
  localparam logic [16:0] CNT_MAX = 17'h1869f;

  // Framing
  localparam logic [7:0] FRAME_LAST = 8'hc0;
  localparam logic [5:0] SF_FRAMES = 6'h0c;
  localparam logic [5:0] ESF_FRAMES = 6'h18;
  localparam logic [11:0] SF_PATTERN = 12'h8dc;
  localparam logic [3:0] SF_PAT_TOP = 4'hb;
  localparam logic [5:0] ESF_FPS = 6'h0b;
  localparam logic [2:0] ESF_FPS_TOP = 3'h5;
  localparam logic [2:0] LOF_ERR_LIMIT = 3'h2;
  localparam logic [5:0] CRC6_POLY = 6'h03;

  // Line code
  localparam logic [7:0] B8ZS_MARKS = 8'h1b;
  localparam logic [7:0] B8ZS_BPVS = 8'h12;
  localparam logic [3:0] ZRUN_LAST = 4'h7;
  localparam logic [3:0] ZRUN_SAT = 4'h8;

  // Alarm detectors
  localparam logic [11:0] ONES_WIN_LAST = 12'hc0f;
  localparam logic [3:0] ONES_MAX_ZEROS = 4'h8;
  localparam logic [7:0] DA_WIN_LAST = 8'hbf;
  localparam logic [3:0] DA_SF_MAX_ONES = 4'h8;
  localparam logic [2:0] DA_ESF_MIN_WORDS = 3'h4;
  localparam logic [15:0] DA_ESF_WORD = 16'hff00;
endpackage

// >>> rtl/prfam_event_counter.sv
// Wrapping event counter with sticky overflow flag
`timescale 1ns/1ps
`default_nettype none
module prfam_event_counter (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic inc,
  input wire logic clr,
  output logic [prfam_pkg::CNT_W-1:0] count_reg,
  output logic ovf_reg
);
  import prfam_pkg::*;

  logic [CNT_W-1:0] count_next;
  logic wrap;

  always_comb begin
    count_next = clr ? '0 : count_reg;
    wrap = inc && (count_next == CNT_MAX);
    if (inc) begin
      count_next = wrap ? '0 : count_next + 1'b1;
    end
  end

  // A clear with an increment in the same cycle leaves a count of one; no overflow is set then
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= '0;
      ovf_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      ovf_reg <= wrap | (ovf_reg & ~clr);
    end
  end
endmodule
`default_nettype wire

// >>> tb/prfam_line_src.sv
// Bipolar line source standing in for the distant transmitter
`timescale 1ns/1ps
`default_nettype none
module prfam_line_src (
  output logic line_clk,
  output logic line_pos,
  output logic line_neg
);
  // Half period 10 ns: four core cycles a symbol keeps the run short
  localparam time HALF = 10;
  logic last_pos;

  initial begin
    line_clk = 1'b0;
    line_pos = 1'b0;
    line_neg = 1'b0;
    last_pos = 1'b0;
  end

  // Symbol set while the clock is low; clock idles low between calls
  task automatic put(input logic p, input logic n);
    line_pos = p;
    line_neg = n;
    #HALF line_clk = 1'b1;
    #HALF line_clk = 1'b0;
  endtask

  // alternate mark inversion
  // A violation repeats the polarity of the previous mark
  task automatic bit_out(input logic b, input logic viol);
    if (b) begin
      if (!viol) begin
        last_pos = ~last_pos;
      end
      put(last_pos, ~last_pos);
    end else begin
      put(1'b0, 1'b0);
    end
  endtask

  // eight-zero substitution
  // Pattern 000VB0VB keeps the line balanced after the code word
  task automatic sub8();
    logic p;
    p = last_pos;
    put(1'b0, 1'b0);
    put(1'b0, 1'b0);
    put(1'b0, 1'b0);
    put(p, ~p);
    put(~p, p);
    put(1'b0, 1'b0);
    put(~p, p);
    put(p, ~p);
    last_pos = p;
  endtask
endmodule
`default_nettype wire

// >>> tb/primary_rate_frame_alarm_monitor_tb.sv
// Self-checking bench for the frame and alarm monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module primary_rate_frame_alarm_monitor_tb;
  import prfam_pkg::*;
  logic core_clk, arst_n, cyc, stb, we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r, q;
  logic ack, line_clk, line_pos, line_neg;
  logic lof_o, all_ones_alarm_o, dist_alarm_o;
  logic code_mismatch_o, dl_bit_o, dl_strobe_o;
  int err_total, num_checks, dl_seen;

  prfam_line_src src_u (
    .line_clk(line_clk),
    .line_pos(line_pos),
    .line_neg(line_neg)
  );

  prfam_monitor dut_u (
    .core_clk(core_clk), .arst_n(arst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .line_clk_i(line_clk), .line_pos_i(line_pos), .line_neg_i(line_neg),
    .lof_o(lof_o), .all_ones_alarm_o(all_ones_alarm_o),
    .dist_alarm_o(dist_alarm_o),
    .code_mismatch_o(code_mismatch_o), .dl_bit_o(dl_bit_o),
    .dl_strobe_o(dl_strobe_o)
  );

  always #2.5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (dl_strobe_o === 1'b1) begin
      dl_seen++;
    end
  end

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Classic single cycle; read data taken at the edge that sees ack
  task automatic wb_xfer(input logic w, input logic [7:0] a,
                         input logic [31:0] d);
    int n;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    if (ack !== 1'b1) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, ack, 1'b1);
      close_out();
    end else begin
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask

  // One frame: the F bit, then the payload as ones
  task automatic send_frame(input logic f);
    src_u.bit_out(f, 1'b0);
    for (int i = 0; i < FRAME_LAST; i++) begin
      src_u.bit_out(1'b1, 1'b0);
    end
  endtask

  // Mid-run reset; the filler puts the next symbol sent, an F bit, on
  // the framer's first candidate slot past the 8-symbol decode delay
  task automatic restart(input logic [31:0] ctrl);
    arst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    `CHK(lof_o, 1'b1)
    wb_xfer(1'b1, ADDR_CTRL, ctrl);
    for (int i = 0; i < FRAME_LAST - 8'h7; i++) begin
      src_u.bit_out(1'b1, 1'b0);
    end
  endtask

  initial begin
    core_clk = 1'b0;
    arst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    dat_w = 32'h0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    `CHK(lof_o, 1'b1)
    wb_xfer(1'b0, ADDR_CTRL, 32'h0);
    `CHK(q[1:0], CTRL_RESET)
    wb_xfer(1'b1, ADDR_CTRL, 32'h3);
    wb_xfer(1'b0, ADDR_CTRL, 32'h0);
    `CHK(q[1:0], 2'h3)
    wb_xfer(1'b1, 8'h0c, 32'hffffffff);
    wb_xfer(1'b0, 8'h0c, 32'h0);
    `CHK(q, 32'h0)
    wb_xfer(1'b1, ADDR_CTRL, 32'h0);
    // Clearing while still hunting must not drop the loss latch
    wb_xfer(1'b1, ADDR_LATCH, 32'hf);
    wb_xfer(1'b0, ADDR_STATUS, 32'h0);
    `CHK(q[ST_LOF], 1'b1)
    `CHK(code_mismatch_o, 1'b0)
    `CHK(lof_o, 1'b1)
    // Ones with a violation and, later, a zero every thousand bits
    for (int i = 0; i < 6200; i++) begin
      src_u.bit_out(!(i >= 3200 && i % 1000 == 500), i % 1000 == 100);
    end
    wb_xfer(1'b0, ADDR_STATUS, 32'h0);
    `CHK(q[ST_ONES], 1'b1)
    `CHK(all_ones_alarm_o, 1'b1)
    `CHK(code_mismatch_o, 1'b0)
    wb_xfer(1'b0, ADDR_CV_CNT, 32'h0);
    `CHK(q[16:0], 17'h0)
    // Plain zero runs under the substituting code are a mismatch
    wb_xfer(1'b1, ADDR_CTRL, 32'h1);
    for (int i = 0; i < 3200; i++) begin
      src_u.bit_out(1'b0, 1'b0);
    end
    `CHK(code_mismatch_o, 1'b1)
    wb_xfer(1'b1, ADDR_CTRL, 32'h0);
    wb_xfer(1'b1, ADDR_LATCH, 32'he);
    wb_xfer(1'b0, ADDR_STATUS, 32'h0);
    `CHK(q[ST_ONES], 1'b0)
    `CHK(all_ones_alarm_o, 1'b0)
    `CHK(code_mismatch_o, 1'b0)
    `CHK(lof_o, 1'b1)
    // Substitution received while plain alternate marks are selected
    for (int i = 0; i < 16; i++) begin
      src_u.bit_out(1'b1, 1'b0);
    end
    src_u.sub8();
    for (int i = 0; i < 16; i++) begin
      src_u.bit_out(1'b1, 1'b0);
    end
    repeat (8) @(posedge core_clk);
    `CHK(code_mismatch_o, 1'b1)
    wb_xfer(1'b0, ADDR_CV_CNT, 32'h0);
    `CHK(q[16:0], 17'h0)
    `CHK(dl_seen, 0)
    // Twelve-frame alignment from a fresh framer, then its loss
    restart(32'h0);
    for (int j = 0; j < 12; j++) begin
      send_frame(SF_PATTERN[11 - j]);
    end
    wb_xfer(1'b0, ADDR_STATUS, 32'h0);
    `CHK(q[ST_LOF], 1'b0)
    `CHK(lof_o, 1'b1)
    `CHK(dist_alarm_o, 1'b0)
    wb_xfer(1'b1, ADDR_LATCH, 32'h1);
    @(posedge core_clk);
    `CHK(lof_o, 1'b0)
    send_frame(~SF_PATTERN[11]);
    send_frame(~SF_PATTERN[10]);
    wb_xfer(1'b0, ADDR_STATUS, 32'h0);
    `CHK(q[ST_LOF], 1'b1)
    wb_xfer(1'b0, ADDR_LOF_CNT, 32'h0);
    `CHK(q[16:0], 17'h1)
    wb_xfer(1'b0, ADDR_FERR_CNT, 32'h0);
    `CHK(q[16:0], 17'h2)
    // Twenty-four-frame alignment; the first data-link bit follows it
    restart(32'h2);
    for (int j = 0; j < 24; j++) begin
      send_frame((j % 4 == 3) ? ESF_FPS[5 - j / 4] : 1'b1);
    end
    wb_xfer(1'b0, ADDR_STATUS, 32'h0);
    `CHK(q[ST_LOF], 1'b0)
    send_frame(1'b1);
    `CHK(dl_seen, 1)
    `CHK(dl_bit_o, 1'b1)
    close_out();
  end
endmodule
`default_nettype wire
